// file: nv_store.sv
// Non-volatile backing store: slow word writes that a supply loss can abort
`timescale 1ns/100ps
`default_nettype none
module nv_store (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Word port
	pstore_nv_if.store nv
);
	// Contents survive rstn; the declaration gives the erased power-on state
	logic [pstore_pkg::DATA_W-1:0] mem [pstore_pkg::NPARAM] = '{default: '0};
	logic busy_r, busy_nxt;
	logic fail_r, fail_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [pstore_pkg::IDX_W-1:0] addr_r, addr_nxt;
	logic [pstore_pkg::DATA_W-1:0] data_r, data_nxt;
	logic [pstore_pkg::DATA_W-1:0] rdata_r;
	logic commit;

	// Write timer; an abort drops the word and leaves the old value
	always_comb begin
		busy_nxt = busy_r;
		fail_nxt = 1'b0;
		cnt_nxt = cnt_r;
		addr_nxt = addr_r;
		data_nxt = data_r;
		commit = 1'b0;
		if (busy_r) begin
			if (nv.abort) begin
				busy_nxt = 1'b0;
				fail_nxt = 1'b1;
			end else if (cnt_r == 8'(pstore_pkg::NV_WRITE_CYCLES - 1)) begin
				busy_nxt = 1'b0;
				commit = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 8'h01;
			end
		end else if (nv.wr) begin
			busy_nxt = 1'b1;
			cnt_nxt = 8'h00;
			addr_nxt = nv.addr;
			data_nxt = nv.wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy_r <= 1'b0;
			fail_r <= 1'b0;
			cnt_r <= 8'h00;
			addr_r <= '0;
			data_r <= '0;
		end else begin
			busy_r <= busy_nxt;
			fail_r <= fail_nxt;
			cnt_r <= cnt_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
		end
	end

	// Array port: commit, and a read registered only when asked for
	always_ff @(posedge clk) begin
		if (commit) begin
			mem[addr_r] <= data_r;
		end
		if (nv.rd) begin
			rdata_r <= mem[nv.addr];
		end
	end

	assign nv.rdata = rdata_r;
	assign nv.busy = busy_r;
	assign nv.fail = fail_r;
endmodule : nv_store
`default_nettype wire

// file: parameter_store_maintenance.sv
// Parameter RAM, update timing, maintenance commands and register port
`timescale 1ns/100ps
`default_nettype none
module parameter_store_maintenance #(
	parameter int unsigned BLINK_HALF_CYCLES = pstore_pkg::BLINK_HALF_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Scanner write handshake
	input wire logic wr_req,
	input wire logic [15:0] wr_id,
	input wire logic [31:0] wr_data,
	output logic wr_end,
	// Device state
	input wire logic ext_alarm,
	input wire logic motor_stopped,
	input wire logic tool_busy,
	input wire logic power_fail,
	// Drive effects
	output logic io_enable,
	output logic motor_excite_en,
	output logic brake_hold,
	output logic [1:0] power_alarm_indicator,
	// Maintenance strobes and alarm
	output logic encoder_origin_preset_cmd,
	output logic maint_strobe,
	output logic [15:0] maint_id,
	output logic [7:0] alarm_code,
	output logic alarm_active,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq
);
	typedef enum logic [2:0] {ST_LOAD_RD, ST_LOAD_WR, ST_IDLE, ST_SAVE_WR, ST_SAVE_WAIT, ST_CONFIG, ST_DONE} state_t;
	localparam int unsigned N = pstore_pkg::NPARAM;

	state_t state_r, state_nxt;
	logic [3:0] idx_r, idx_nxt;
	logic [11:0] cnt_r, cnt_nxt;
	logic boot_r, boot_nxt, boot_apply_r, boot_apply_nxt, cfg_apply_r, cfg_apply_nxt;
	logic [7:0] alarm_r, alarm_nxt;
	logic [3:0] hist_r, hist_nxt;
	logic [4:0] status_r, status_nxt, mask_r, mask_nxt, ev;
	logic [31:0] ram_r [N];
	logic [31:0] ram_nxt [N];
	logic [31:0] applied_r [N];
	logic [N-1:0] set_w, pend_r;
	logic [31:0] rdata_r, rdata_nxt;
	logic wr_end_r, io_en_r, preset_r, preset_nxt, mstb_r, mstb_nxt;
	logic [15:0] mid_r, mid_nxt;
	logic [1:0] led_r, led_nxt;
	logic [25:0] blink_cnt_r, blink_cnt_nxt;
	logic blink_r, blink_nxt;
	logic pf_meta_r, pf_sync_r;
	logic take, is_param, cfg_ok, alarm_any;
	pstore_nv_if nv ();

	nv_store u_nv (
		.clk(clk),
		.rstn(rstn),
		.nv(nv.store)
	);

	// Supply-loss pin crosses in through two flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pf_meta_r <= 1'b0;
			pf_sync_r <= 1'b0;
		end else begin
			pf_meta_r <= power_fail;
			pf_sync_r <= pf_meta_r;
		end
	end
	assign nv.abort = pf_sync_r;

	assign alarm_any = ext_alarm | (alarm_r != pstore_pkg::ALARM_NONE);
	assign cfg_ok = !alarm_any && motor_stopped && !tool_busy;
	assign take = (state_r == ST_IDLE) && wr_req;
	assign is_param = (wr_id[15:4] == pstore_pkg::PARAM_ID_PAGE);

	// Command sequencer; boot starts with the storage-to-RAM copy
	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		cnt_nxt = cnt_r;
		boot_nxt = boot_r;
		boot_apply_nxt = 1'b0;
		cfg_apply_nxt = 1'b0;
		alarm_nxt = alarm_r;
		hist_nxt = hist_r;
		preset_nxt = 1'b0;
		mstb_nxt = 1'b0;
		mid_nxt = mid_r;
		ev = '0;
		set_w = '0;
		nv.rd = 1'b0;
		nv.wr = 1'b0;
		nv.addr = idx_r;
		nv.wdata = ram_r[idx_r];
		for (int i = 0; i < N; i++) begin
			ram_nxt[i] = ram_r[i];
		end
		case (state_r)
			ST_LOAD_RD: begin
				nv.rd = 1'b1;
				state_nxt = ST_LOAD_WR;
			end
			ST_LOAD_WR: begin
				ram_nxt[idx_r] = nv.rdata;
				set_w[idx_r] = 1'b1;
				if (idx_r == pstore_pkg::IDX_LAST) begin
					if (boot_r) begin
						boot_nxt = 1'b0;
						boot_apply_nxt = 1'b1;
						state_nxt = ST_IDLE;
					end else begin
						ev[pstore_pkg::ST_LOAD_DONE] = 1'b1;
						state_nxt = ST_DONE;
					end
				end else begin
					idx_nxt = idx_r + 4'h1;
					state_nxt = ST_LOAD_RD;
				end
			end
			ST_IDLE: begin
				if (take) begin
					state_nxt = ST_DONE;
					idx_nxt = 4'h0;
					if (is_param) begin
						ram_nxt[wr_id[3:0]] = wr_data;
						set_w[wr_id[3:0]] = 1'b1;
					end else if (wr_id == pstore_pkg::ID_ALARM_RESET) begin
						alarm_nxt = pstore_pkg::ALARM_NONE;
					end else if (wr_id == pstore_pkg::ID_CONFIG) begin
						if (cfg_ok) begin
							cnt_nxt = 12'h000;
							state_nxt = ST_CONFIG;
						end else begin
							ev[pstore_pkg::ST_CFG_REFUSED] = 1'b1;
						end
					end else if (wr_id == pstore_pkg::ID_INIT_KEEP_COMM || wr_id == pstore_pkg::ID_INIT_ALL) begin
						for (int i = 0; i < N; i++) begin
							if (wr_id == pstore_pkg::ID_INIT_ALL || 4'(i) < pstore_pkg::COMM_FIRST) begin
								ram_nxt[i] = pstore_pkg::default_of(4'(i));
								set_w[i] = 1'b1;
							end
						end
					end else if (wr_id == pstore_pkg::ID_NV_LOAD) begin
						state_nxt = ST_LOAD_RD;
					end else if (wr_id == pstore_pkg::ID_NV_SAVE) begin
						state_nxt = ST_SAVE_WR;
					end else if (wr_id == pstore_pkg::ID_HIST_SEL) begin
						if (wr_data <= pstore_pkg::HIST_MAX) begin
							hist_nxt = wr_data[3:0];
						end
					end else if (wr_id >= pstore_pkg::ID_MAINT_FIRST && wr_id < pstore_pkg::ID_HIST_SEL) begin
						mstb_nxt = 1'b1;
						mid_nxt = wr_id;
						preset_nxt = (wr_id == pstore_pkg::ID_ORIGIN_PRESET);
					end
				end
			end
			ST_SAVE_WR: begin
				nv.wr = 1'b1;
				state_nxt = ST_SAVE_WAIT;
			end
			ST_SAVE_WAIT: begin
				if (nv.fail) begin
					alarm_nxt = pstore_pkg::ALARM_NV_ERROR;
					ev[pstore_pkg::ST_NV_ERR] = 1'b1;
					state_nxt = ST_DONE;
				end else if (!nv.busy) begin
					if (idx_r == pstore_pkg::IDX_LAST) begin
						ev[pstore_pkg::ST_SAVE_DONE] = 1'b1;
						state_nxt = ST_DONE;
					end else begin
						idx_nxt = idx_r + 4'h1;
						state_nxt = ST_SAVE_WR;
					end
				end
			end
			ST_CONFIG: begin
				if (cnt_r == 12'(pstore_pkg::CONFIG_CYCLES - 1)) begin
					cfg_apply_nxt = 1'b1;
					ev[pstore_pkg::ST_CFG_DONE] = 1'b1;
					state_nxt = ST_DONE;
				end else begin
					cnt_nxt = cnt_r + 12'h001;
				end
			end
			ST_DONE: begin
				if (!wr_req) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Indicator: blue blink in configuration, red on alarm, else green
	always_comb begin
		blink_cnt_nxt = 26'h0000000;
		blink_nxt = 1'b1;
		if (state_r == ST_CONFIG) begin
			blink_cnt_nxt = blink_cnt_r + 26'h0000001;
			blink_nxt = blink_r;
			if (blink_cnt_r == 26'(BLINK_HALF_CYCLES - 1)) begin
				blink_cnt_nxt = 26'h0000000;
				blink_nxt = !blink_r;
			end
		end
		if (state_nxt == ST_CONFIG) begin
			led_nxt = blink_nxt ? pstore_pkg::LED_BLUE : pstore_pkg::LED_OFF;
		end else if (alarm_any) begin
			led_nxt = pstore_pkg::LED_RED;
		end else begin
			led_nxt = pstore_pkg::LED_GREEN;
		end
	end

	// Register port; a new event wins over a same-cycle clear
	always_comb begin
		mask_nxt = mask_r;
		status_nxt = status_r | ev;
		rdata_nxt = 32'h00000000;
		if (reg_wr && reg_addr == pstore_pkg::REG_STATUS) begin
			status_nxt = (status_r & ~reg_wdata[4:0]) | ev;
		end else if (reg_wr && reg_addr == pstore_pkg::REG_MASK) begin
			mask_nxt = reg_wdata[4:0];
		end
		if (reg_rd) begin
			if (reg_addr == pstore_pkg::REG_STATUS) begin
				rdata_nxt = {27'h0000000, status_r};
			end else if (reg_addr == pstore_pkg::REG_MASK) begin
				rdata_nxt = {27'h0000000, mask_r};
			end else if (reg_addr == pstore_pkg::REG_ALARM) begin
				rdata_nxt = {24'h000000, alarm_r};
			end else if (reg_addr == pstore_pkg::REG_HIST) begin
				rdata_nxt = {28'h0000000, hist_r};
			end else if (reg_addr == pstore_pkg::REG_STATE) begin
				rdata_nxt = {28'h0000000, boot_r, nv.busy, state_r == ST_CONFIG, state_r == ST_IDLE};
			end else if (reg_addr[7:6] == pstore_pkg::REG_APPLIED_PAGE && reg_addr[1:0] == 2'h0) begin
				rdata_nxt = applied_r[reg_addr[5:2]];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_LOAD_RD;
			idx_r <= 4'h0;
			cnt_r <= 12'h000;
			boot_r <= 1'b1;
			boot_apply_r <= 1'b0;
			cfg_apply_r <= 1'b0;
			alarm_r <= pstore_pkg::ALARM_NONE;
			hist_r <= pstore_pkg::HIST_NONE;
			status_r <= pstore_pkg::STATUS_RST;
			mask_r <= pstore_pkg::MASK_RST;
			rdata_r <= 32'h00000000;
			wr_end_r <= 1'b0;
			io_en_r <= 1'b0;
			preset_r <= 1'b0;
			mstb_r <= 1'b0;
			mid_r <= 16'h0000;
			led_r <= pstore_pkg::LED_OFF;
			blink_cnt_r <= 26'h0000000;
			blink_r <= 1'b1;
			for (int i = 0; i < N; i++) begin
				ram_r[i] <= 32'h00000000;
			end
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			cnt_r <= cnt_nxt;
			boot_r <= boot_nxt;
			boot_apply_r <= boot_apply_nxt;
			cfg_apply_r <= cfg_apply_nxt;
			alarm_r <= alarm_nxt;
			hist_r <= hist_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			rdata_r <= rdata_nxt;
			wr_end_r <= (state_nxt == ST_DONE);
			io_en_r <= (state_nxt != ST_CONFIG) && !boot_nxt;
			preset_r <= preset_nxt;
			mstb_r <= mstb_nxt;
			mid_r <= mid_nxt;
			led_r <= led_nxt;
			blink_cnt_r <= blink_cnt_nxt;
			blink_r <= blink_nxt;
			for (int i = 0; i < N; i++) begin
				ram_r[i] <= ram_nxt[i];
			end
		end
	end

	// Per-slot pending flag and applied copy; a write in the apply cycle stays pending
	for (genvar i = 0; i < N; i++) begin : g_slot
		localparam pstore_pkg::upd_class_t CLS = pstore_pkg::class_of(4'(i));
		logic go, pend_nxt;
		logic [31:0] appl_nxt;
		always_comb begin
			case (CLS)
				pstore_pkg::CLS_A: go = 1'b1;
				pstore_pkg::CLS_B: go = motor_stopped;
				pstore_pkg::CLS_C: go = cfg_apply_r;
				default: go = 1'b0;
			endcase
			appl_nxt = applied_r[i];
			pend_nxt = pend_r[i] | set_w[i];
			if (boot_apply_r || (pend_r[i] && go)) begin
				appl_nxt = ram_r[i];
				pend_nxt = set_w[i];
			end
		end
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				pend_r[i] <= 1'b0;
				applied_r[i] <= 32'h00000000;
			end else begin
				pend_r[i] <= pend_nxt;
				applied_r[i] <= appl_nxt;
			end
		end
		if (CLS == pstore_pkg::CLS_A) begin : g_a
			class_a_a: assert property (@(posedge clk) disable iff (!rstn) set_w[i] |=> ##1 (applied_r[i] == ram_r[i]))
				else $error("class A value not applied two cycles after write");
		end
		if (CLS == pstore_pkg::CLS_B) begin : g_b
			class_b_a: assert property (@(posedge clk) disable iff (!rstn) (pend_r[i] && !motor_stopped && !boot_apply_r) |=> ($stable(applied_r[i]) && pend_r[i]))
				else $error("class B value applied while motor running");
		end
		if (CLS == pstore_pkg::CLS_C) begin : g_c
			class_c_a: assert property (@(posedge clk) disable iff (!rstn) (pend_r[i] && cfg_apply_r && !set_w[i]) |=> (!pend_r[i] && applied_r[i] == $past(ram_r[i])))
				else $error("class C value not applied after configuration");
		end
		if (CLS == pstore_pkg::CLS_D) begin : g_d
			class_d_a: assert property (@(posedge clk) disable iff (!rstn) (pend_r[i] && !boot_apply_r) |=> pend_r[i])
				else $error("class D value applied without power cycle");
		end
	end

	assign wr_end = wr_end_r;
	assign io_enable = io_en_r;
	assign motor_excite_en = io_en_r;
	assign brake_hold = !io_en_r;
	assign power_alarm_indicator = led_r;
	assign encoder_origin_preset_cmd = preset_r;
	assign maint_strobe = mstb_r;
	assign maint_id = mid_r;
	assign alarm_code = alarm_r;
	assign alarm_active = alarm_any;
	assign reg_rdata = rdata_r;
	assign irq = |(status_r & mask_r);

	// Checks on the command sequencer
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence take_s(logic [15:0] id);
		take && wr_id == id;
	endsequence
	sequence save_steps_s;
		state_r == ST_SAVE_WR ##1 state_r == ST_SAVE_WAIT;
	endsequence

	nv_save_seq_a: assert property (take_s(pstore_pkg::ID_NV_SAVE) |=> save_steps_s)
		else $error("save command did not start storage write");
	nv_only_save_a: assert property (nv.wr |-> state_r == ST_SAVE_WR)
		else $error("storage written outside a save");
	nv_alarm_a: assert property ((state_r == ST_SAVE_WAIT && nv.fail) |=> alarm_code == pstore_pkg::ALARM_NV_ERROR)
		else $error("aborted storage write raised no alarm");
	boot_apply_a: assert property ($fell(boot_r) |-> boot_apply_r && state_r == ST_IDLE)
		else $error("boot load ended without apply");
	init_keep_a: assert property (take_s(pstore_pkg::ID_INIT_KEEP_COMM) |=> (ram_r[N-1] == $past(ram_r[N-1])
		&& ram_r[0] == pstore_pkg::default_of(4'h0)))
		else $error("keep-comm initialization wrong");
	init_all_a: assert property (take_s(pstore_pkg::ID_INIT_ALL) |=> ram_r[N-1] == pstore_pkg::default_of(4'hF))
		else $error("full initialization left comm slot");
	hist_range_a: assert property ((take_s(pstore_pkg::ID_HIST_SEL) and (wr_data > pstore_pkg::HIST_MAX)) |=> $stable(hist_r))
		else $error("history selector took out-of-range value");
	cfg_gate_a: assert property ((take_s(pstore_pkg::ID_CONFIG) and !cfg_ok) |=> state_r == ST_DONE && status_r[4])
		else $error("configuration ran while not allowed");
	cfg_io_a: assert property ((state_r == ST_CONFIG) |-> (!io_enable && !motor_excite_en && brake_hold))
		else $error("I/O or motor active during configuration");
	param_done_a: assert property ((take && is_param) |=> wr_end && state_r == ST_DONE)
		else $error("parameter write not answered");
	end_low_a: assert property ((state_r == ST_DONE && !wr_req) |=> !wr_end ##1 !wr_end)
		else $error("write done stayed high after request dropped");
	preset_once_a: assert property (take_s(pstore_pkg::ID_ORIGIN_PRESET) |=> encoder_origin_preset_cmd ##1 !encoder_origin_preset_cmd)
		else $error("origin preset strobe not a single pulse");
endmodule : parameter_store_maintenance
`default_nettype wire

// file: pstore_nv_if.sv
// Word port between the parameter store and its non-volatile backing store
`timescale 1ns/100ps
`default_nettype none
interface pstore_nv_if;
	logic rd;
	logic wr;
	logic [pstore_pkg::IDX_W-1:0] addr;
	logic [pstore_pkg::DATA_W-1:0] wdata;
	logic [pstore_pkg::DATA_W-1:0] rdata;
	logic busy;
	logic fail;
	logic abort;

	modport ctrl (output rd, output wr, output addr, output wdata, output abort,
		input rdata, input busy, input fail);
	modport store (input rd, input wr, input addr, input wdata, input abort,
		output rdata, output busy, output fail);
endinterface : pstore_nv_if
`default_nettype wire

// file: pstore_pkg.sv
// Constants, types and helpers shared by the parameter store and its non-volatile backing store
package pstore_pkg;
	typedef enum logic [1:0] {CLS_A, CLS_B, CLS_C, CLS_D} upd_class_t;

	// Parameter slots, all one data width wide
	localparam int unsigned DATA_W = 32;
	localparam int unsigned IDX_W = 4;
	localparam int unsigned NPARAM = 16;
	localparam int unsigned ID_W = 16;
	localparam logic [IDX_W-1:0] IDX_LAST = 4'hF;
	localparam logic [IDX_W-1:0] COMM_FIRST = 4'hC;
	localparam logic [11:0] PARAM_ID_PAGE = 12'h020;

	// Maintenance command IDs
	localparam logic [ID_W-1:0] ID_MAINT_FIRST = 16'h00C0;
	localparam logic [ID_W-1:0] ID_ALARM_RESET = 16'h00C0;
	localparam logic [ID_W-1:0] ID_CONFIG = 16'h00C6;
	localparam logic [ID_W-1:0] ID_INIT_KEEP_COMM = 16'h00C7;
	localparam logic [ID_W-1:0] ID_NV_LOAD = 16'h00C8;
	localparam logic [ID_W-1:0] ID_NV_SAVE = 16'h00C9;
	localparam logic [ID_W-1:0] ID_INIT_ALL = 16'h00CA;
	localparam logic [ID_W-1:0] ID_ORIGIN_PRESET = 16'h00D1;
	localparam logic [ID_W-1:0] ID_HIST_SEL = 16'h00D5;

	// Alarm and history selector
	localparam logic [7:0] ALARM_NONE = 8'h00;
	localparam logic [7:0] ALARM_NV_ERROR = 8'h41;
	localparam logic [3:0] HIST_NONE = 4'h0;
	localparam logic [DATA_W-1:0] HIST_MAX = 32'h0000000A;

	// Indicator codes
	localparam logic [1:0] LED_OFF = 2'h0;
	localparam logic [1:0] LED_GREEN = 2'h1;
	localparam logic [1:0] LED_BLUE = 2'h2;
	localparam logic [1:0] LED_RED = 2'h3;

	// Register port offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_MASK = 8'h04;
	localparam logic [7:0] REG_ALARM = 8'h08;
	localparam logic [7:0] REG_HIST = 8'h0C;
	localparam logic [7:0] REG_STATE = 8'h10;
	localparam logic [1:0] REG_APPLIED_PAGE = 2'h1;

	// Status bits and reset values
	localparam int unsigned STAT_W = 5;
	localparam int unsigned ST_NV_ERR = 0;
	localparam int unsigned ST_SAVE_DONE = 1;
	localparam int unsigned ST_LOAD_DONE = 2;
	localparam int unsigned ST_CFG_DONE = 3;
	localparam int unsigned ST_CFG_REFUSED = 4;
	localparam logic [STAT_W-1:0] STATUS_RST = 5'h00;
	localparam logic [STAT_W-1:0] MASK_RST = 5'h00;
	localparam logic [DATA_W-1:0] DEFAULT_BASE = 32'h00000100;

	// Timing
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned NV_WORD_WRITE_NS = 1000;
	localparam int unsigned NV_WRITE_CYCLES = (NV_WORD_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CONFIG_TIME_NS = 20000;
	localparam int unsigned CONFIG_CYCLES = (CONFIG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BLINK_HALF_MS = 250;
	localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;

	// Update class of each slot, cycling A, B, C, D
	function automatic upd_class_t class_of(input logic [IDX_W-1:0] idx);
		return upd_class_t'(idx[1:0]);
	endfunction : class_of

	// Default value of each slot
	function automatic logic [DATA_W-1:0] default_of(input logic [IDX_W-1:0] idx);
		return DEFAULT_BASE | {28'h0000000, idx};
	endfunction : default_of
endpackage : pstore_pkg

// file: scanner_model.sv
// Network scanner model that writes parameters through the request and done handshake
`timescale 1ns/100ps
`default_nettype none
module scanner_model (
	// Clock
	input wire logic clk,
	// Write handshake
	output logic wr_req,
	output logic [15:0] wr_id,
	output logic [31:0] wr_data,
	input wire logic wr_end
);
	initial begin
		wr_req = 1'b0;
		wr_id = 16'h0000;
		wr_data = 32'h0000;
	end

	// One write; ok drops if done never comes or never returns low
	task automatic send(input logic [15:0] id, input logic [31:0] d, input int lim, output bit ok);
		int n;
		wr_req <= 1'b1;
		wr_id <= id;
		wr_data <= d;
		for (n = 0; n < lim && wr_end !== 1'b1; n++) @(posedge clk);
		ok = (n < lim);
		wr_req <= 1'b0;
		// Released lines show the inverse, never a stale copy
		wr_id <= ~id;
		wr_data <= ~d;
		for (n = 0; n < 8 && wr_end !== 1'b0; n++) @(posedge clk);
		ok = ok && (n < 8);
		// Spacing so storage commands never come in quick succession
		repeat (4) @(posedge clk);
	endtask : send
endmodule : scanner_model
`default_nettype wire

// file: test_parameter_store_maintenance.sv
// Self-checking bench for the parameter store and maintenance commands
`timescale 1ns/100ps
`default_nettype none
module test_parameter_store_maintenance;
	// Stimulus held by the bench
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ext_alarm = 1'b0;
	logic motor_stopped = 1'b1;
	logic tool_busy = 1'b0;
	logic power_fail = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	// Design outputs and handshake
	logic wr_req, wr_end, io_enable, motor_excite_en, brake_hold, irq;
	logic encoder_origin_preset_cmd, maint_strobe, alarm_active;
	logic [15:0] wr_id, maint_id;
	logic [31:0] wr_data, reg_rdata;
	logic [1:0] power_alarm_indicator;
	logic [7:0] alarm_code;
	// Bench state
	int failures = 0;
	int num_checks = 0;
	int presets = 0;
	int strobes = 0;
	logic rd_d = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] seed = 32'h9;
	logic [31:0] d[4];

	always #2.5 clk = ~clk;

	parameter_store_maintenance #(.BLINK_HALF_CYCLES(8)) uut (.clk(clk), .rstn(rstn), .wr_req(wr_req),
		.wr_id(wr_id), .wr_data(wr_data), .wr_end(wr_end), .ext_alarm(ext_alarm),
		.motor_stopped(motor_stopped), .tool_busy(tool_busy), .power_fail(power_fail),
		.io_enable(io_enable), .motor_excite_en(motor_excite_en), .brake_hold(brake_hold),
		.power_alarm_indicator(power_alarm_indicator), .encoder_origin_preset_cmd(encoder_origin_preset_cmd),
		.maint_strobe(maint_strobe), .maint_id(maint_id), .alarm_code(alarm_code),
		.alarm_active(alarm_active), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

	scanner_model scn (.clk(clk), .wr_req(wr_req), .wr_id(wr_id), .wr_data(wr_data), .wr_end(wr_end));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	// Read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		if (rd_d) chk(reg_rdata, exp_q.pop_front());
		rd_d <= reg_rd;
	end

	always @(posedge clk) if (encoder_origin_preset_cmd === 1'b1) presets++;
	always @(posedge clk) if (maint_strobe === 1'b1) strobes++;

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic cmd(input logic [15:0] id, input logic [31:0] v, input int lim);
		bit ok;
		scn.send(id, v, lim, ok);
		chk(32'(ok), 32'h1);
	endtask : cmd

	// Reset, then wait a bounded time for the boot copy to finish
	task automatic restart();
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 100 && io_enable !== 1'b1; i++) @(posedge clk);
		chk(32'(io_enable), 32'h1);
	endtask : restart

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	initial begin
		restart();
		chk(32'(brake_hold), 32'h0);
		rd(pstore_pkg::REG_STATE, 32'h1);
		rd(pstore_pkg::REG_MASK, 32'h0);
		rd(pstore_pkg::REG_STATUS, 32'h0);
		rd(8'h20, 32'h0);
		$display("test boot done");
		// Motor running: only class A may apply
		motor_stopped <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			d[i] = rnd();
			cmd(16'h0200 + 16'(i), d[i], 8);
		end
		rd(8'h40, d[0]);
		rd(8'h44, 32'h0);
		rd(8'h48, 32'h0);
		motor_stopped <= 1'b1;
		repeat (3) @(posedge clk);
		rd(8'h44, d[1]);
		$display("test classes done");
		fork
			cmd(pstore_pkg::ID_CONFIG, rnd(), 5000);
			begin
				repeat (4) @(posedge clk);
				chk({30'h0, io_enable, motor_excite_en}, 32'h0);
				chk(32'(brake_hold), 32'h1);
				chk(32'(power_alarm_indicator), 32'(pstore_pkg::LED_BLUE));
			end
		join
		chk(32'(io_enable), 32'h1);
		rd(8'h48, d[2]);
		rd(8'h4C, 32'h0);
		rd(pstore_pkg::REG_STATUS, 32'h8);
		$display("test config done");
		// Each blocking condition alone must refuse configuration
		wr(pstore_pkg::REG_MASK, 32'h10);
		for (int k = 0; k < 3; k++) begin
			ext_alarm <= (k == 0);
			tool_busy <= (k == 1);
			motor_stopped <= (k != 2);
			cmd(pstore_pkg::ID_CONFIG, 32'h0, 8);
			chk(32'(io_enable), 32'h1);
		end
		ext_alarm <= 1'b0;
		tool_busy <= 1'b0;
		motor_stopped <= 1'b1;
		chk(32'(irq), 32'h1);
		rd(pstore_pkg::REG_STATUS, 32'h18);
		wr(pstore_pkg::REG_STATUS, 32'h18);
		chk(32'(irq), 32'h0);
		$display("test refusal done");
		cmd(pstore_pkg::ID_NV_SAVE, 32'h0, 4000);
		cmd(16'h0200, rnd(), 8);
		restart();
		rd(8'h40, d[0]);
		rd(8'h4C, d[3]);
		cmd(pstore_pkg::ID_NV_LOAD, 32'h0, 100);
		rd(pstore_pkg::REG_STATUS, 32'h4);
		$display("test storage done");
		cmd(16'h020C, d[1], 8);
		cmd(pstore_pkg::ID_INIT_KEEP_COMM, 32'h0, 100);
		rd(8'h40, 32'h100);
		rd(8'h70, d[1]);
		cmd(pstore_pkg::ID_INIT_ALL, 32'h0, 100);
		rd(8'h70, 32'h10C);
		cmd(pstore_pkg::ID_HIST_SEL, 32'h5, 8);
		cmd(pstore_pkg::ID_HIST_SEL, 32'hB, 8);
		rd(pstore_pkg::REG_HIST, 32'h5);
		cmd(pstore_pkg::ID_ORIGIN_PRESET, rnd(), 8);
		cmd(pstore_pkg::ID_ORIGIN_PRESET, 32'h0, 8);
		chk(32'(presets), 32'h2);
		cmd(16'h00CF, rnd(), 8);
		chk(32'(maint_id), 32'hCF);
		chk(32'(strobes), 32'h3);
		$display("test commands done");
		// Supply loss partway through a save
		fork
			cmd(pstore_pkg::ID_NV_SAVE, 32'h0, 4000);
			begin
				repeat (300) @(posedge clk);
				power_fail <= 1'b1;
			end
		join
		power_fail <= 1'b0;
		chk(32'(alarm_code), 32'h41);
		chk(32'(alarm_active), 32'h1);
		rd(pstore_pkg::REG_ALARM, 32'h41);
		cmd(pstore_pkg::ID_ALARM_RESET, 32'h0, 8);
		chk(32'(alarm_code), 32'h0);
		$display("test alarm done");
		end_of_test();
	end

	// Whole run is about 8k cycles; this limit of 100k cycles is over ten times that
	initial begin
		#500000;
		failures++;
		end_of_test();
	end
endmodule : test_parameter_store_maintenance
`default_nettype wire
